// File: board_strap_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Board straps and reset source
// ****
module board_strap_model (
  input wire logic mclk,
  input wire logic rst_req,
  input wire logic [2:0] code,
  input wire logic pwr,
  output logic nrst = 1'b0,
  output logic [2:0] sel = 3'h0,
  output logic local_power_detect = 1'b0
);
  int low_cnt = 200;
  always @(posedge mclk) begin
    low_cnt <= rst_req ? 200 : (low_cnt > 0 ? low_cnt - 1 : 0);
    nrst <= !rst_req && low_cnt == 0;
    sel <= (code[2:1] == 2'b11) ? 3'h0 : code;
    local_power_detect <= pwr;
  end
endmodule // board_strap_model
`default_nettype wire

// File: hub_cfg_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checks
// ****
module hub_cfg_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic local_power_detect,
  input wire logic [3:0] port_owner_select_pins,
  input wire hub_cfg_pkg::hub_cfg_s cfg,
  input wire logic [6:0] smbus_addr,
  input wire logic local_power,
  input wire logic [2:0] embedded_config
);
  logic [3:0] rel_cnt;
  wire logic done = (rel_cnt == 4'hF);
  logic rst_seen = 1'b0;
  always @(posedge mclk) rst_seen <= !nrst;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) rel_cnt <= 4'h0;
    else if (!done) rel_cnt <= rel_cnt + 4'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  reset_clear_a: assert property (disable iff (1'b0)
    !nrst && rst_seen |-> embedded_config == 3'h0 && smbus_addr == 7'h0)
    else $error("not cleared");
  cfg_hold_a: assert property (done |-> $stable(cfg)) else $error("cfg moved");
  smb_addr_a: assert property (done |-> smbus_addr ==
    (cfg.method == hub_cfg_pkg::METHOD_SMBUS ? 7'h2C : 7'h0)) else $error("smbus addr");
  level_mode_a: assert property (done && cfg.pa_mode == hub_cfg_pkg::PA_LEVEL |->
    !cfg.unassign_ok && cfg.strap_en && cfg.led_mode == hub_cfg_pkg::LED_USB)
    else $error("level mode");
  edge_mode_a: assert property (done && cfg.pa_mode == hub_cfg_pkg::PA_EDGE |->
    cfg.unassign_ok && (cfg.led_mode == hub_cfg_pkg::LED_HOST) == cfg.strap_en)
    else $error("edge mode");
  emb_hold_a: assert property (done && cfg.pa_mode != hub_cfg_pkg::PA_EMBEDDED |->
    $stable(embedded_config)) else $error("owner moved");
  emb_follow_a: assert property ((done && cfg.pa_mode == hub_cfg_pkg::PA_EMBEDDED)
    ##0 $stable(port_owner_select_pins)[*8] |-> embedded_config == port_owner_select_pins[2:0])
    else $error("owner wrong");
  pwr_follow_a: assert property ($stable(local_power_detect)[*8] |->
    local_power == local_power_detect) else $error("power wrong");
endmodule // hub_cfg_checker
`default_nettype wire

// File: hub_cfg_pkg.sv
`default_nettype none
package hub_cfg_pkg;

  // ****************************************
  // Select codes
  // ****************************************
  localparam logic [2:0] SEL_DEFAULT = 3'h0;
  localparam logic [2:0] SEL_SMBUS = 3'h1;
  localparam logic [2:0] SEL_LEVEL = 3'h2;
  localparam logic [2:0] SEL_EEPROM = 3'h3;
  localparam logic [2:0] SEL_EDGE = 3'h4;
  localparam logic [2:0] SEL_EDGE_SPEED = 3'h5;
  localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2C;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] OFS_CONFIG = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_OWNER = 32'h0000_0008;
  localparam int STAT_SEL_LSB = 0;
  localparam int STAT_METHOD_LSB = 3;
  localparam int STAT_PAMODE_LSB = 5;
  localparam int STAT_LED_LSB = 7;
  localparam int STAT_STRAP_EN = 9;
  localparam int STAT_UNASSIGN = 10;
  localparam int STAT_LOCAL_PWR = 11;
  localparam int STAT_RESERVED = 12;
  localparam int STAT_PINS_LSB = 13;
  localparam int STAT_SMB_LSB = 17;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    METHOD_INTERNAL = 2'b00,
    METHOD_SMBUS = 2'b01,
    METHOD_EEPROM = 2'b10,
    METHOD_NONE = 2'b11
  } method_e;

  typedef enum logic [1:0] {
    PA_EMBEDDED = 2'b00,
    PA_LEVEL = 2'b01,
    PA_EDGE = 2'b10,
    PA_EXTERNAL = 2'b11
  } pa_mode_e;

  typedef enum logic [1:0] {
    LED_USB = 2'b00,
    LED_HOST = 2'b01,
    LED_HOST_SPEED = 2'b10,
    LED_LOADED = 2'b11
  } led_mode_e;

  typedef struct packed {
    method_e method;
    pa_mode_e pa_mode;
    led_mode_e led_mode;
    logic strap_en;
    logic unassign_ok;
    logic reserved;
  } hub_cfg_s;

endpackage

`default_nettype wire

// File: hub_config_strap_decoder.sv
// Summary of operation
// RULE_01: The three select inputs are caught as reset releases and pick the configuration method.
// RULE_02: Code 000 gives internal defaults, embedded port assignment, strap pins on, USB LED mode.
// RULE_03: Code 001 makes an SMBus slave at address 0101100, strap pins off, LED mode from download.
// RULE_04: Code 010 gives level-triggered assignment, strap pins on, USB LEDs, no unassigned ports.
// RULE_05: Code 011 loads configuration from an I2C EEPROM with LED mode from the load.
// RULE_06: Code 100 gives edge-triggered assignment, host LEDs, strap pins on, unassigned allowed.
// RULE_07: Code 101 gives edge-triggered assignment, host and speed LEDs, strap pins off, unassigned.
// RULE_08: The board never straps code 110 or 111, which are reserved.
// RULE_09: Reset is held low for at least 1 us each time.
// RULE_10: Local power detect low means bus powered only, high means local supply present.
// RULE_11: The test input is left open or grounded and never used.
// RULE_12: The device clock is 24 MHz from a crystal or an external clock; CLK_PERIOD_PS and the bench use a 5 ns (200 MHz) mclk instead.
// RULE_13: The chosen configuration holds until the next reset whatever the select inputs do.
// RULE_14: Port owner select pins are ignored while the device is in reset.
// RULE_15: In embedded mode only the low three owner pins pick one of eight configurations.
`timescale 1ns/10ps
`default_nettype none

module hub_config_strap_decoder (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic config_method_select_bit0,
  input wire logic config_method_select_bit1,
  input wire logic config_method_select_bit2,
  input wire logic local_power_detect,
  input wire logic [3:0] port_owner_select_pins,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output hub_cfg_pkg::hub_cfg_s cfg,
  output logic [6:0] smbus_addr,
  output logic local_power,
  output logic [2:0] embedded_config
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sel_s1, sel_s2, sel_s3;
  logic [4:0] pin_s1, pin_s2, pin_s3;
  logic [4:0] pin_stable;
  logic [2:0] sel_stable;
  logic [1:0] rel_cnt;
  logic captured;
  wire [2:0] sel_raw = {config_method_select_bit2, config_method_select_bit1,
                        config_method_select_bit0};
  wire [4:0] pin_raw = {local_power_detect, port_owner_select_pins};

  // Straps tracked through reset
  always_ff @(posedge mclk) begin
    sel_s1 <= sel_raw;
    sel_s2 <= sel_s1;
    sel_s3 <= sel_s2;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  wire [4:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire [2:0] sel_agree = ~(sel_s2 ^ sel_s3);

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          pin_stable[gi] <= 1'b0;
        end else if (pin_agree[gi]) begin
          pin_stable[gi] <= pin_s3[gi];
        end
      end
    end
    for (gi = 0; gi < 3; gi++) begin : g_sel
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          sel_stable[gi] <= 1'b0;
        end else if (sel_agree[gi]) begin
          sel_stable[gi] <= sel_s3[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Capture at reset release
  // ****************************************
  logic [2:0] sel_code;
  wire capture_now = !captured && (rel_cnt == 2'h3);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt <= 2'h0;
      captured <= 1'b0;
      sel_code <= 3'h0;
    end else begin
      if (rel_cnt != 2'h3) begin
        rel_cnt <= rel_cnt + 2'h1;
      end
      if (capture_now) begin
        captured <= 1'b1;                          // [RULE_13]
        sel_code <= sel_stable;                    // [RULE_01]
      end
    end
  end

  // ****************************************
  // Configuration decode
  // ****************************************
  hub_cfg_pkg::hub_cfg_s next_cfg;

  always_comb begin
    next_cfg = '{hub_cfg_pkg::METHOD_NONE, hub_cfg_pkg::PA_EXTERNAL,
                 hub_cfg_pkg::LED_LOADED, 1'b0, 1'b0, 1'b1};
    unique case (sel_code)
      hub_cfg_pkg::SEL_DEFAULT: begin
        next_cfg = '{hub_cfg_pkg::METHOD_INTERNAL, hub_cfg_pkg::PA_EMBEDDED,
                     hub_cfg_pkg::LED_USB, 1'b1, 1'b1, 1'b0};          // [RULE_02]
      end
      hub_cfg_pkg::SEL_SMBUS: begin
        next_cfg = '{hub_cfg_pkg::METHOD_SMBUS, hub_cfg_pkg::PA_EXTERNAL,
                     hub_cfg_pkg::LED_LOADED, 1'b0, 1'b1, 1'b0};       // [RULE_03]
      end
      hub_cfg_pkg::SEL_LEVEL: begin
        next_cfg = '{hub_cfg_pkg::METHOD_INTERNAL, hub_cfg_pkg::PA_LEVEL,
                     hub_cfg_pkg::LED_USB, 1'b1, 1'b0, 1'b0};          // [RULE_04]
      end
      hub_cfg_pkg::SEL_EEPROM: begin
        next_cfg = '{hub_cfg_pkg::METHOD_EEPROM, hub_cfg_pkg::PA_EXTERNAL,
                     hub_cfg_pkg::LED_LOADED, 1'b0, 1'b1, 1'b0};       // [RULE_05]
      end
      hub_cfg_pkg::SEL_EDGE: begin
        next_cfg = '{hub_cfg_pkg::METHOD_INTERNAL, hub_cfg_pkg::PA_EDGE,
                     hub_cfg_pkg::LED_HOST, 1'b1, 1'b1, 1'b0};         // [RULE_06]
      end
      hub_cfg_pkg::SEL_EDGE_SPEED: begin
        next_cfg = '{hub_cfg_pkg::METHOD_INTERNAL, hub_cfg_pkg::PA_EDGE,
                     hub_cfg_pkg::LED_HOST_SPEED, 1'b0, 1'b1, 1'b0};   // [RULE_07]
      end
      default: begin
        next_cfg = '{hub_cfg_pkg::METHOD_NONE, hub_cfg_pkg::PA_EXTERNAL,
                     hub_cfg_pkg::LED_LOADED, 1'b0, 1'b0, 1'b1};       // [RULE_08]
      end
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [2:0] owner_cfg;
  logic [31:0] config_reg;
  wire owner_live = captured && (cfg.pa_mode == hub_cfg_pkg::PA_EMBEDDED);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg <= '{hub_cfg_pkg::METHOD_NONE, hub_cfg_pkg::PA_EXTERNAL,
               hub_cfg_pkg::LED_LOADED, 1'b0, 1'b0, 1'b0};
      smbus_addr <= 7'h00;
      local_power <= 1'b0;
      owner_cfg <= 3'h0;
    end else begin
      if (captured) begin
        cfg <= next_cfg;
        smbus_addr <= (sel_code == hub_cfg_pkg::SEL_SMBUS) ?
                      hub_cfg_pkg::SMBUS_SLAVE_ADDR : 7'h00;  // [RULE_03]
      end
      local_power <= pin_stable[4];                           // [RULE_10]
      if (owner_live) begin
        owner_cfg <= pin_stable[2:0];                         // [RULE_14] [RULE_15]
      end
    end
  end

  assign embedded_config = owner_cfg;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic dp_write;
  logic [31:0] dp_addr;
  wire take = hsel && hready && htrans[1];
  wire cfg_bypass = dp_write && (dp_addr == hub_cfg_pkg::OFS_CONFIG);
  wire [31:0] config_now = cfg_bypass ? {31'h0000_0000, hwdata[0]} : config_reg;
  wire [31:0] status_word = {8'h00, smbus_addr, pin_stable[3:0], cfg.reserved,
                             local_power, cfg.unassign_ok, cfg.strap_en, cfg.led_mode,
                             cfg.pa_mode, cfg.method, sel_code};
  wire [31:0] owner_word = {29'h0000_0000, owner_cfg};
  wire [31:0] next_rdata = (haddr == hub_cfg_pkg::OFS_CONFIG) ? config_now :
                           (haddr == hub_cfg_pkg::OFS_STATUS) ? status_word :
                           (haddr == hub_cfg_pkg::OFS_OWNER) ? owner_word : 32'h0000_0000;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dp_write <= 1'b0;
      dp_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      dp_write <= take && hwrite;
      hrdata <= (take && !hwrite) ? next_rdata : 32'h0000_0000;
      if (take) begin
        dp_addr <= haddr;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      config_reg <= hub_cfg_pkg::CONFIG_RESET;
    end else if (dp_write && dp_addr == hub_cfg_pkg::OFS_CONFIG) begin
      config_reg <= {31'h0000_0000, hwdata[0]};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule // hub_config_strap_decoder

`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Strap decoder bench
// ****
module tb;
  logic mclk = 1'b0, rst_req = 1'b0, pwr = 1'b0, hwrite = 1'b0, hsel = 1'b0;
  logic nrst, lpd, hreadyout, hresp, local_power;
  logic [1:0] htrans = 2'h0;
  logic [2:0] code = 3'h0, sel, embedded_config;
  logic [3:0] owner = 4'h0;
  logic [2:0] hsize = 3'h2;
  logic [6:0] smbus_addr;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  hub_cfg_pkg::hub_cfg_s cfg;
  int err_total = 0, check_count = 0;
  logic [7:0] ex_t [6] = '{8'h40, 8'h3D, 8'h44, 8'h3E, 8'hD8, 8'hA8};
  logic [7:0] mk_t [6] = '{8'h7F, 8'h7F, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
  always #2.5 mclk = ~mclk;
  board_strap_model u_board_strap_model (.mclk, .rst_req, .code, .pwr, .nrst, .sel,
    .local_power_detect(lpd));
  hub_config_strap_decoder u_hub_config_strap_decoder (.mclk, .nrst, .hsize,
    .config_method_select_bit0(sel[0]), .config_method_select_bit1(sel[1]),
    .config_method_select_bit2(sel[2]), .local_power_detect(lpd), .hready(hreadyout),
    .port_owner_select_pins(owner), .haddr, .htrans, .hwrite, .hsel, .hwdata, .hrdata,
    .hreadyout, .hresp, .cfg, .smbus_addr, .local_power, .embedded_config);
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    {hsel, hwrite, htrans, haddr} <= {1'b1, wr, 2'h2, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic reboot(input logic [2:0] c);
    code <= c;
    rst_req <= 1'b1;
    @(posedge mclk);
    rst_req <= 1'b0;
    do @(posedge mclk); while (nrst !== 1'b1);
    repeat (10) @(posedge mclk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (int c = 5; c >= 0; c--) begin
      owner <= 4'(c + 9);
      reboot(3'(c));
      xfer(1'b0, hub_cfg_pkg::OFS_STATUS, 32'h0);
      chk("code", 32'(c), 32'(rd[2:0]));
      chk("mode", 32'(ex_t[c]), 32'(rd[10:3] & mk_t[c]));
      chk("smbus", c == 1 ? 32'h2C : 32'h0, 32'(smbus_addr));
      $display("test code %0d done", c);
    end
    code <= 3'h5;
    pwr <= 1'b1;
    owner <= 4'hD;
    repeat (10) @(posedge mclk);
    xfer(1'b0, hub_cfg_pkg::OFS_STATUS, 32'h0);
    chk("hold", 32'h40, 32'(rd[10:3] & 8'h7F));
    chk("power", 32'h1, 32'(rd[11]));
    xfer(1'b0, hub_cfg_pkg::OFS_OWNER, 32'h0);
    chk("owner", 32'h5, rd);
    xfer(1'b1, hub_cfg_pkg::OFS_CONFIG, 32'h1);
    xfer(1'b0, hub_cfg_pkg::OFS_CONFIG, 32'h0);
    chk("scratch", 32'h1, rd);
    xfer(1'b1, 32'h10, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("resp", 32'h0, 32'(hresp));
    $display("test hold and registers done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end
endmodule // tb
bind hub_config_strap_decoder hub_cfg_checker u_hub_cfg_checker (.mclk, .nrst, .cfg,
  .local_power_detect, .port_owner_select_pins, .smbus_addr, .local_power, .embedded_config);
`default_nettype wire
